// ### blcfg_params.svh
/*
  constants for the backlight configuration register pair: offsets,
  field positions, reset values and decode widths.
  assumes it is included by bare name from the block and its testbench.
*/
// What this block does
// RQ1: first register bit 5 selects phase-staggered dimming, else ordinary pwm.
// RQ2: first register bits 4:0 give the pwm frequency code to the generator.
// RQ3: second register bits 7:6 select resolution, 8..10 bits up to 11..13 bits.
// RQ4: second register bit 5 adds the external set resistor to current code.
// RQ5: second register bit 4 picks fault threshold, 0 for 3.3V, 1 for 5.3V.
// RQ6: second register bits 2:0 set headroom, 125 mV steps from 125 to 1000.
// RQ7: first register bits 7:6 select lockout level, code 00 disables it.
`ifndef BLCFG_PARAMS_SVH
`define BLCFG_PARAMS_SVH

// ----------------------------------------
// offsets and reset values
// ----------------------------------------
`define BLCFG_OFS_LOCKOUT_DIM 8'ha3
`define BLCFG_OFS_RES_HEADROOM 8'ha4
`define BLCFG_RST_LOCKOUT_DIM 8'h00
`define BLCFG_RST_RES_HEADROOM 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define BLCFG_LOCKOUT_HI 7
`define BLCFG_LOCKOUT_LO 6
`define BLCFG_STAGGER_BIT 5
`define BLCFG_FREQ_HI 4
`define BLCFG_FREQ_LO 0
`define BLCFG_RESOL_HI 7
`define BLCFG_RESOL_LO 6
`define BLCFG_EXTRES_BIT 5
`define BLCFG_FAULT_BIT 4
`define BLCFG_SLOPE0_BIT 3
`define BLCFG_HEADR_HI 2
`define BLCFG_HEADR_LO 0

// ----------------------------------------
// decode figures
// ----------------------------------------
`define BLCFG_RESOL_MIN_BITS 4'h8
`define BLCFG_RESOL_SPAN 4'h2
`define BLCFG_HEADR_STEP_MV 11'h07d

`endif

// ### blcfg_pkg.sv
/*
  types for the backlight configuration register pair.
  assumes nothing beyond the params header.
*/
package blcfg_pkg;
  typedef enum logic [1:0] {
    BLCFG_LOCKOUT_OFF = 2'h0,
    BLCFG_LOCKOUT_LOW = 2'h1,
    BLCFG_LOCKOUT_MID = 2'h2,
    BLCFG_LOCKOUT_HIGH = 2'h3
  } blcfg_lockout_t;
  typedef enum logic {
    BLCFG_THR_LOW = 1'b0,
    BLCFG_THR_HIGH = 1'b1
  } blcfg_fault_thr_t;
endpackage

// ### blcfg_regs.sv
/*
  two 8-bit configuration registers of a backlight driver with decoded
  selects for dimming, fault and boost logic.
  assumes a single core_clk domain and a same-clock plain register port.
*/
`timescale 1ns/10ps
`include "blcfg_params.svh"

module blcfg_regs (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  output blcfg_pkg::blcfg_lockout_t        supply_lockout_level_sel,
  output logic                             supply_lockout_enable,
  output logic                             phase_stagger_enable,
  output logic      [4:0]                  dim_freq_code,
  output logic      [1:0]                  dim_resolution_sel,
  output logic      [3:0]                  dim_resolution_min_bits,
  output logic      [3:0]                  dim_resolution_max_bits,
  output logic                             ext_resistor_current_enable,
  output blcfg_pkg::blcfg_fault_thr_t      string_fault_threshold_sel,
  output logic                             current_slope_low_bit,
  output logic      [2:0]                  sink_headroom_sel,
  output logic      [10:0]                 sink_headroom_mv
);

  // ----------------------------------------
  // storage and address decode
  // ----------------------------------------
  logic [7:0] lock_dim_r;
  logic [7:0] res_head_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // one offset compare shared by both registers; the width is pinned to the
  // eight-bit port, so a wider offset constant is cut to its low eight bits without notice
  function automatic logic addr_hit(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return (addr == ofs);
  endfunction

  wire        hit_lock = addr_hit(reg_addr, `BLCFG_OFS_LOCKOUT_DIM);
  wire        hit_res  = addr_hit(reg_addr, `BLCFG_OFS_RES_HEADROOM);

  // unmapped offsets read as zero; a read with no strobe returns zero too
  assign rdata_nxt = !reg_rd ? 8'h00 :
                     hit_lock ? lock_dim_r :
                     hit_res ? res_head_r : 8'h00;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lock_dim_r <= `BLCFG_RST_LOCKOUT_DIM;
      res_head_r <= `BLCFG_RST_RES_HEADROOM;
      rdata_r    <= 8'h00;
    end else begin
      if (reg_wr && hit_lock) begin
        lock_dim_r <= reg_wdata;
      end
      if (reg_wr && hit_res) begin
        res_head_r <= reg_wdata;
      end
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------
  // decoded selects, all straight from stored bits
  // ----------------------------------------
  assign supply_lockout_level_sel = blcfg_pkg::blcfg_lockout_t'(
    lock_dim_r[`BLCFG_LOCKOUT_HI:`BLCFG_LOCKOUT_LO]); // RQ7
  assign supply_lockout_enable = (supply_lockout_level_sel != blcfg_pkg::BLCFG_LOCKOUT_OFF); // RQ7
  assign phase_stagger_enable = lock_dim_r[`BLCFG_STAGGER_BIT]; // RQ1
  assign dim_freq_code = lock_dim_r[`BLCFG_FREQ_HI:`BLCFG_FREQ_LO]; // RQ2
  assign dim_resolution_sel = res_head_r[`BLCFG_RESOL_HI:`BLCFG_RESOL_LO]; // RQ3
  // each code step adds one bit; the top of the span applies at the lowest frequency
  assign dim_resolution_min_bits = `BLCFG_RESOL_MIN_BITS + {2'h0, dim_resolution_sel}; // RQ3
  assign dim_resolution_max_bits = dim_resolution_min_bits + `BLCFG_RESOL_SPAN; // RQ3
  assign ext_resistor_current_enable = res_head_r[`BLCFG_EXTRES_BIT]; // RQ4
  assign string_fault_threshold_sel = blcfg_pkg::blcfg_fault_thr_t'(
    res_head_r[`BLCFG_FAULT_BIT]); // RQ5
  assign current_slope_low_bit = res_head_r[`BLCFG_SLOPE0_BIT];
  assign sink_headroom_sel = res_head_r[`BLCFG_HEADR_HI:`BLCFG_HEADR_LO]; // RQ6
  // headroom above saturation in mV: (code + 1) steps
  assign sink_headroom_mv = 11'(({8'h00, sink_headroom_sel} + 11'h001) * `BLCFG_HEADR_STEP_MV); // RQ6

  // ----------------------------------------
  // check sequences
  // ----------------------------------------
  // the bus master never raises both strobes at once, so each access
  // sequence names one strobe and requires the other low
  sequence s_write_lock;
    reg_wr && !reg_rd && hit_lock;
  endsequence

  sequence s_write_res;
    reg_wr && !reg_rd && hit_res;
  endsequence

  sequence s_read_lock;
    reg_rd && !reg_wr && hit_lock;
  endsequence

  sequence s_read_res;
    reg_rd && !reg_wr && hit_res;
  endsequence

  sequence s_read_unmapped;
    reg_rd && !reg_wr && !hit_lock && !hit_res;
  endsequence

  // reset is sampled here so that an attempt started on the reset edge
  // does not count the step back to reset values as a spurious change
  sequence s_lock_idle;
    !rst && !(reg_wr && hit_lock);
  endsequence

  sequence s_res_idle;
    !rst && !(reg_wr && hit_res);
  endsequence

  sequence s_no_read;
    !reg_rd;
  endsequence

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_stagger_follows_write: assert property (@(posedge core_clk) disable iff (rst) // RQ1
    reg_wr && hit_lock |=> phase_stagger_enable == $past(reg_wdata[5]))
    else $error("stagger select did not follow write");

  a_freq_code_write: assert property (@(posedge core_clk) disable iff (rst) // RQ2
    reg_wr && hit_lock |=> dim_freq_code == $past(reg_wdata[4:0]))
    else $error("frequency code did not follow write");

  a_resol_span_check: assert property (@(posedge core_clk) disable iff (rst) // RQ3
    dim_resolution_max_bits == 4'h0a + {2'h0, res_head_r[7:6]}
    && dim_resolution_min_bits == 4'h8 + {2'h0, res_head_r[7:6]})
    else $error("resolution bit span wrong");

  a_extres_write: assert property (@(posedge core_clk) disable iff (rst) // RQ4
    reg_wr && hit_res |=> ext_resistor_current_enable == $past(reg_wdata[5]))
    else $error("resistor select did not follow write");

  a_fault_thr_write: assert property (@(posedge core_clk) disable iff (rst) // RQ5
    reg_wr && hit_res |=> string_fault_threshold_sel == $past(reg_wdata[4]))
    else $error("fault threshold did not follow write");

  a_headroom_mv_map: assert property (@(posedge core_clk) disable iff (rst) // RQ6
    reg_wr && hit_res && reg_wdata[2:0] == 3'h7 |=> sink_headroom_mv == 11'h3e8)
    else $error("top headroom code not 1000 mV");

  a_lockout_off_code: assert property (@(posedge core_clk) disable iff (rst) // RQ7
    reg_wr && hit_lock && reg_wdata[7:6] == 2'h0 |=> !supply_lockout_enable)
    else $error("lockout not disabled by code 00");

  a_readback_cycle: assert property (@(posedge core_clk) disable iff (rst) // RQ6
    reg_rd && hit_res && !reg_wr |=> reg_rdata == $past(res_head_r))
    else $error("readback wrong");

  // ----------------------------------------
  // write follow checks
  // ----------------------------------------
  a_lockout_level_write: assert property (@(posedge core_clk) disable iff (rst) // RQ7
    s_write_lock |=> supply_lockout_level_sel == $past(reg_wdata[7:6]))
    else $error("lockout level did not follow write");

  a_lockout_enable_write: assert property (@(posedge core_clk) disable iff (rst) // RQ7
    s_write_lock |=> supply_lockout_enable == ($past(reg_wdata[7:6]) != 2'h0))
    else $error("lockout enable did not follow write");

  a_resol_sel_write: assert property (@(posedge core_clk) disable iff (rst) // RQ3
    s_write_res |=> dim_resolution_sel == $past(reg_wdata[7:6]))
    else $error("resolution code did not follow write");

  a_resol_top_code: assert property (@(posedge core_clk) disable iff (rst) // RQ3
    s_write_res ##0 reg_wdata[7:6] == 2'h3 |=>
      dim_resolution_min_bits == 4'hb && dim_resolution_max_bits == 4'hd)
    else $error("top resolution code not 11 to 13 bits");

  a_headroom_sel_write: assert property (@(posedge core_clk) disable iff (rst) // RQ6
    s_write_res |=> sink_headroom_sel == $past(reg_wdata[2:0]))
    else $error("headroom code did not follow write");

  a_headroom_low_code: assert property (@(posedge core_clk) disable iff (rst) // RQ6
    s_write_res ##0 reg_wdata[2:0] == 3'h0 |=> sink_headroom_mv == 11'h07d)
    else $error("lowest headroom code not 125 mV");

  a_slope_bit_write: assert property (@(posedge core_clk) disable iff (rst)
    s_write_res |=> current_slope_low_bit == $past(reg_wdata[3]))
    else $error("slope bit did not follow write");

  // ----------------------------------------
  // hold checks
  // ----------------------------------------
  // selects feed analog trims, so any change without a write is a glitch
  a_lock_hold_idle: assert property (@(posedge core_clk) disable iff (rst)
    s_lock_idle |=> $stable(supply_lockout_level_sel) && $stable(phase_stagger_enable)
      && $stable(dim_freq_code))
    else $error("first register selects changed without a write");

  a_res_hold_idle: assert property (@(posedge core_clk) disable iff (rst)
    s_res_idle |=> $stable(dim_resolution_sel) && $stable(ext_resistor_current_enable)
      && $stable(string_fault_threshold_sel) && $stable(current_slope_low_bit)
      && $stable(sink_headroom_sel))
    else $error("second register selects changed without a write");

  // ----------------------------------------
  // read checks
  // ----------------------------------------
  a_lock_readback: assert property (@(posedge core_clk) disable iff (rst) // RQ2
    s_read_lock |=> reg_rdata == $past(lock_dim_r))
    else $error("first register readback wrong");

  a_read_unmapped_zero: assert property (@(posedge core_clk) disable iff (rst)
    s_read_unmapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_rdata_idle_zero: assert property (@(posedge core_clk) disable iff (rst)
    s_no_read |=> reg_rdata == 8'h00)
    else $error("read data not zero without a read");

  a_write_read_lock: assert property (@(posedge core_clk) disable iff (rst)
    s_write_lock ##1 s_read_lock |=> reg_rdata == $past(reg_wdata, 2))
    else $error("read right after write missed new first register value");

  a_write_read_res: assert property (@(posedge core_clk) disable iff (rst)
    s_write_res ##1 s_read_res |=> reg_rdata == $past(reg_wdata, 2))
    else $error("read right after write missed new second register value");

  // ----------------------------------------
  // reset checks
  // ----------------------------------------
  a_reset_values: assert property (@(posedge core_clk)
    rst |=> supply_lockout_level_sel == blcfg_pkg::BLCFG_LOCKOUT_OFF && !phase_stagger_enable
      && dim_freq_code == 5'h00 && dim_resolution_min_bits == 4'h8
      && sink_headroom_mv == 11'h07d && reg_rdata == 8'h00)
    else $error("outputs not at reset values after reset");
endmodule

// ### tb.sv
/* testbench for the backlight configuration register pair: corner and random writes,
   readback, unmapped access, mid-run reset. assumes blcfg_regs, its header and package. */
`timescale 1ns/10ps
`include "blcfg_params.svh"
module tb;
  logic        core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, m3, m4, d;
  logic        supply_lockout_enable, phase_stagger_enable, ext_resistor_current_enable;
  logic        current_slope_low_bit;
  logic [4:0]  dim_freq_code;
  logic [1:0]  dim_resolution_sel;
  logic [3:0]  dim_resolution_min_bits, dim_resolution_max_bits;
  logic [2:0]  sink_headroom_sel;
  logic [10:0] sink_headroom_mv;
  blcfg_pkg::blcfg_lockout_t   supply_lockout_level_sel;
  blcfg_pkg::blcfg_fault_thr_t string_fault_threshold_sel;
  int          error_cnt = 0, n_checks = 0, cyc = 0, r;
  localparam logic [7:0] A3 = `BLCFG_OFS_LOCKOUT_DIM, A4 = `BLCFG_OFS_RES_HEADROOM;
  localparam logic [7:0] CV [5] = '{8'hff, 8'h00, 8'h40, 8'h80, 8'hc0};
  blcfg_regs DUT (
    .core_clk                    (core_clk),
    .rst                         (rst),
    .reg_addr                    (reg_addr),
    .reg_wdata                   (reg_wdata),
    .reg_wr                      (reg_wr),
    .reg_rd                      (reg_rd),
    .reg_rdata                   (reg_rdata),
    .supply_lockout_level_sel    (supply_lockout_level_sel),
    .supply_lockout_enable       (supply_lockout_enable),
    .phase_stagger_enable        (phase_stagger_enable),
    .dim_freq_code               (dim_freq_code),
    .dim_resolution_sel          (dim_resolution_sel),
    .dim_resolution_min_bits     (dim_resolution_min_bits),
    .dim_resolution_max_bits     (dim_resolution_max_bits),
    .ext_resistor_current_enable (ext_resistor_current_enable),
    .string_fault_threshold_sel  (string_fault_threshold_sel),
    .current_slope_low_bit       (current_slope_low_bit),
    .sink_headroom_sel           (sink_headroom_sel),
    .sink_headroom_mv            (sink_headroom_mv)
  );
  always #50 core_clk = ~core_clk;
  // -----------------------------
  // helpers
  // -----------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // a hang counts as a mismatch; the run needs well under 2000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // headroom in mV above saturation, one entry per code
  function automatic logic [10:0] hmv(input logic [2:0] c);
    case (c)
      3'h0: return 11'h07d;
      3'h1: return 11'h0fa;
      3'h2: return 11'h177;
      3'h3: return 11'h1f4;
      3'h4: return 11'h271;
      3'h5: return 11'h2ee;
      3'h6: return 11'h36b;
      default: return 11'h3e8;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a == A3) m3 = v;
    if (a == A4) m4 = v;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk({3'h0, reg_rdata}, {3'h0, e});
    @(posedge core_clk);
    #1 chk({3'h0, reg_rdata}, 11'h000);
  endtask
  // write then read the same register with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk({3'h0, reg_rdata}, {3'h0, v});
    @(posedge core_clk);
    #1 chk({3'h0, reg_rdata}, 11'h000);
    if (a == A3) m3 = v;
    if (a == A4) m4 = v;
  endtask
  task automatic chk_all();
    #1 chk(supply_lockout_level_sel, m3[7:6]);
    chk(supply_lockout_enable, |m3[7:6]);
    chk(phase_stagger_enable, m3[5]);
    chk(dim_freq_code, m3[4:0]);
    chk(dim_resolution_sel, m4[7:6]);
    chk(dim_resolution_min_bits, 4'h8 + m4[7:6]);
    chk(dim_resolution_max_bits, 4'ha + m4[7:6]);
    chk(ext_resistor_current_enable, m4[5]);
    chk(string_fault_threshold_sel, m4[4]);
    chk(current_slope_low_bit, m4[3]);
    chk(sink_headroom_sel, m4[2:0]);
    chk(sink_headroom_mv, hmv(m4[2:0]));
  endtask
  // -----------------------------
  // tests
  // -----------------------------
  initial begin
    r = $urandom(93);
    m3 = 8'h00;
    m4 = 8'h00;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    chk_all();
    $display("test reset done");
    foreach (CV[i]) begin
      wr(A3, CV[i]);
      wr(A4, ~CV[i]);
      chk_all();
    end
    wr_rd(A4, 8'he7);
    chk_all();
    wr_rd(A3, 8'h9f);
    chk_all();
    $display("test corners done");
    repeat (40) begin
      d = 8'($urandom);
      wr(($urandom % 2) ? A3 : A4, d);
      chk_all();
      rd(A3, m3);
      rd(A4, m4);
    end
    $display("test random done");
    // unmapped write must leave both registers alone and read back zero
    wr(8'ha5, 8'hff);
    chk_all();
    rd(8'ha5, 8'h00);
    $display("test unmapped done");
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    m3 = 8'h00;
    m4 = 8'h00;
    chk_all();
    $display("test second reset done");
    finish_test();
  end
endmodule
